// *** dmbm_mapper.v ***
// Data memory address mapper with bank selector and general RAM
// Operation
// - Window low 96 to bank 0, rest bank 15
// - Window is split in two at offset 60h, not one linear range
// - Select bit 1: bank selector plus offset
// - Select bit 0: window map, ignore bank selector
// - Window access completes in one cycle
// - Extended enable applies modified window mapping
// - General RAM starts at 000h below registers
// - General RAM not cleared by any reset

`include "dmbm_consts.vh"

module dmbm_mapper #(
  parameter RAM_AW = 11
)(
  input wire CLK_SYS_IN,
  input wire RESET_IN,
  input wire BANK_WR_IN,
  input wire [`DMBM_BANK_W-1:0] BANK_DATA_IN,
  input wire EXTENDED_INSTRUCTION_ENABLE_IN,
  input wire [`DMBM_ADDR_W-1:0] INDEX_BASE_IN,
  input wire REQ_IN,
  input wire ACCESS_SEL_IN,
  input wire [`DMBM_OFS_W-1:0] OFFSET_IN,
  input wire WR_IN,
  input wire [`DMBM_DATA_W-1:0] WDATA_IN,
  input wire [`DMBM_DATA_W-1:0] SFR_RDATA_IN,
  output wire [`DMBM_BANK_W-1:0] BANK_OUT,
  output wire [`DMBM_ADDR_W-1:0] ADDR_OUT,
  output wire ADDR_VALID_OUT,
  output wire RAM_HIT_OUT,
  output wire SFR_HIT_OUT,
  output wire SFR_WR_OUT,
  output wire [`DMBM_DATA_W-1:0] SFR_WDATA_OUT,
  output wire [`DMBM_DATA_W-1:0] RDATA_OUT
);

  localparam RAM_DEPTH = 1 << RAM_AW;
  // Last implemented RAM address, built at the address width
  localparam [`DMBM_ADDR_W-1:0] RAM_LAST =
    {`DMBM_ADDR_W{1'b1}} >> (`DMBM_ADDR_W - RAM_AW);

  // Bank selector register
  reg [`DMBM_BANK_W-1:0] bank_selector_register_q;

  // Registered request results
  reg [`DMBM_ADDR_W-1:0] addr_q;
  reg valid_q;
  reg ram_hit_q;
  reg sfr_hit_q;
  reg sfr_wr_q;
  reg [`DMBM_DATA_W-1:0] sfr_wdata_q;
  reg [`DMBM_DATA_W-1:0] rdata_q;

  // General RAM storage, deliberately without any reset
  reg [`DMBM_DATA_W-1:0] general_ram_location [0:RAM_DEPTH-1];

  reg [`DMBM_ADDR_W-1:0] window_addr;
  reg [`DMBM_ADDR_W-1:0] addr_d;
  reg [`DMBM_DATA_W-1:0] rdata_d;
  wire low_half;
  wire below_sfr;
  wire within_ram;
  wire ram_hit_d;
  wire sfr_hit_d;
  wire ram_wr;
  wire sfr_wr_d;
  wire [RAM_AW-1:0] ram_index;
  wire [`DMBM_DATA_W-1:0] ram_rdata;

  // Offsets below the split fall in the general RAM half of the window
  assign low_half = (OFFSET_IN < `DMBM_WIN_SPLIT);

  // Forced window: picked by the 8-bit offset, plus the index base in the low half when extended is enabled
  always @*
  begin
    if (low_half && EXTENDED_INSTRUCTION_ENABLE_IN)
    begin
      // Indexed form: low half is relative to the index base
      window_addr = INDEX_BASE_IN + {`DMBM_WIN_LOW_BANK, OFFSET_IN};
    end
    else if (low_half)
    begin
      window_addr = {`DMBM_WIN_LOW_BANK, OFFSET_IN};
    end
    else
    begin
      window_addr = {`DMBM_WIN_HIGH_BANK, OFFSET_IN};
    end
  end

  // Address source chosen by the instruction's access-select bit
  always @*
  begin
    if (ACCESS_SEL_IN == `DMBM_SEL_BANKED)
    begin
      addr_d = {bank_selector_register_q, OFFSET_IN};
    end
    else
    begin
      // Bank selector plays no part here
      addr_d = window_addr;
    end
  end

  // General RAM runs from 000h up to RAM_LAST, below the register region
  assign below_sfr = (addr_d < `DMBM_SFR_START);
  // Space above the implemented RAM and below the registers is a hole
  assign within_ram = (addr_d <= RAM_LAST);
  assign ram_hit_d = below_sfr && within_ram;
  assign sfr_hit_d = !below_sfr;
  assign ram_index = addr_d[RAM_AW-1:0];

  // Write strobes for each region
  assign ram_wr = REQ_IN && WR_IN && ram_hit_d;
  assign sfr_wr_d = REQ_IN && WR_IN && sfr_hit_d;

  // Continuous read so a fresh write is seen by the next request
  assign ram_rdata = general_ram_location[ram_index];

  // Read data: RAM, register space, or zero for unimplemented space
  always @*
  begin
    if (ram_hit_d)
    begin
      rdata_d = ram_rdata;
    end
    else if (sfr_hit_d)
    begin
      rdata_d = SFR_RDATA_IN;
    end
    else
    begin
      rdata_d = `DMBM_DATA_RST;
    end
  end

  // RAM write port; contents survive every reset
  always @(posedge CLK_SYS_IN)
  begin
    if (ram_wr)
    begin
      general_ram_location[ram_index] <= WDATA_IN;
    end
  end

  // Bank selector; a request in the same cycle still sees the old value
  always @(posedge CLK_SYS_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      bank_selector_register_q <= `DMBM_BANK_RST;
    end
    else if (BANK_WR_IN)
    begin
      bank_selector_register_q <= BANK_DATA_IN;
    end
  end

  // Valid and register-space write strobes stand for one cycle only
  always @(posedge CLK_SYS_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      valid_q <= `DMBM_FLAG_RST;
      sfr_wr_q <= `DMBM_FLAG_RST;
    end
    else
    begin
      valid_q <= REQ_IN;
      sfr_wr_q <= sfr_wr_d;
    end
  end

  // Request results are registered at the edge after the request and held until the next request
  always @(posedge CLK_SYS_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      addr_q <= `DMBM_ADDR_RST;
      ram_hit_q <= `DMBM_FLAG_RST;
      sfr_hit_q <= `DMBM_FLAG_RST;
    end
    else if (REQ_IN)
    begin
      addr_q <= addr_d;
      ram_hit_q <= ram_hit_d;
      sfr_hit_q <= sfr_hit_d;
    end
  end

  // Read data of the last request; a same-cycle write is not seen
  always @(posedge CLK_SYS_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      rdata_q <= `DMBM_DATA_RST;
    end
    else if (REQ_IN)
    begin
      rdata_q <= rdata_d;
    end
  end

  // Data of the last write, handed on towards register space
  always @(posedge CLK_SYS_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      sfr_wdata_q <= `DMBM_DATA_RST;
    end
    else if (REQ_IN && WR_IN)
    begin
      sfr_wdata_q <= WDATA_IN;
    end
  end

  assign BANK_OUT = bank_selector_register_q;
  assign ADDR_OUT = addr_q;
  assign ADDR_VALID_OUT = valid_q;
  assign RAM_HIT_OUT = ram_hit_q;
  assign SFR_HIT_OUT = sfr_hit_q;
  assign SFR_WR_OUT = sfr_wr_q;
  assign SFR_WDATA_OUT = sfr_wdata_q;
  assign RDATA_OUT = rdata_q;

endmodule // dmbm_mapper

// *** dmbm_consts.vh ***
// Constants for the data memory bank mapper
`ifndef DMBM_CONSTS_VH
`define DMBM_CONSTS_VH

// Width of the data memory address, bank selector, opcode address and data
`define DMBM_ADDR_W 12
`define DMBM_BANK_W 4
`define DMBM_OFS_W 8
`define DMBM_DATA_W 8

// Forced window split: offsets below this go to bank 0, or to index base plus offset when extended is enabled
`define DMBM_WIN_SPLIT 8'h60
`define DMBM_WIN_LOW_BANK 4'h0
`define DMBM_WIN_HIGH_BANK 4'hF

// First address of the special function register region
`define DMBM_SFR_START 12'hF60

// Access-select encodings in the instruction
`define DMBM_SEL_BANKED 1'b1
`define DMBM_SEL_FORCED 1'b0

// Reset values
`define DMBM_BANK_RST 4'h0
`define DMBM_ADDR_RST 12'h000
`define DMBM_DATA_RST 8'h00
`define DMBM_FLAG_RST 1'b0

`endif

// *** dmbm_checker.sv ***
// Port assertions for the data memory bank mapper
module dmbm_checker #(parameter RAM_AW = 11) (
  input wire CLK_SYS_IN,
  input wire RESET_IN,
  input wire EXTENDED_INSTRUCTION_ENABLE_IN,
  input wire [11:0] INDEX_BASE_IN,
  input wire REQ_IN,
  input wire ACCESS_SEL_IN,
  input wire [7:0] OFFSET_IN,
  input wire [3:0] BANK_OUT,
  input wire [11:0] ADDR_OUT,
  input wire ADDR_VALID_OUT,
  input wire RAM_HIT_OUT,
  input wire SFR_HIT_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);
  wire fw = REQ_IN && !ACCESS_SEL_IN;
  wire lo = OFFSET_IN < 8'h60;
  wire ex = EXTENDED_INSTRUCTION_ENABLE_IN;
  valid_pulse_a: assert property (REQ_IN |=> ADDR_VALID_OUT)
    else $error("no valid");
  idle_quiet_a: assert property (!REQ_IN |=> !ADDR_VALID_OUT)
    else $error("stray valid");
  banked_addr_a: assert property (REQ_IN && ACCESS_SEL_IN |=>
    ADDR_OUT == {$past(BANK_OUT), $past(OFFSET_IN)}) else $error("banked");
  low_win_a: assert property (fw && lo && !ex |=>
    ADDR_OUT == {4'h0, $past(OFFSET_IN)}) else $error("low window");
  high_win_a: assert property (fw && !lo |=>
    ADDR_OUT == {4'hF, $past(OFFSET_IN)}) else $error("high window");
  ext_win_a: assert property (fw && lo && ex |=>
    ADDR_OUT == $past(INDEX_BASE_IN) + $past(OFFSET_IN)) else $error("ext");
  sfr_hit_a: assert property (ADDR_VALID_OUT |->
    SFR_HIT_OUT == (ADDR_OUT >= 12'hF60)) else $error("sfr hit");
  ram_hit_a: assert property (ADDR_VALID_OUT |->
    RAM_HIT_OUT == ((ADDR_OUT >> RAM_AW) == 0)) else $error("ram hit");
endmodule // dmbm_checker
bind dmbm_mapper dmbm_checker #(.RAM_AW(RAM_AW)) u_chk (.*);

// *** tb.sv ***
// Testbench for the data memory bank mapper
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS_IN, RESET_IN, BANK_WR_IN, REQ_IN, ACCESS_SEL_IN, WR_IN;
  logic EXTENDED_INSTRUCTION_ENABLE_IN, ADDR_VALID_OUT, RAM_HIT_OUT;
  logic SFR_HIT_OUT, SFR_WR_OUT;
  logic [3:0] BANK_DATA_IN, BANK_OUT;
  logic [7:0] OFFSET_IN, WDATA_IN, SFR_RDATA_IN, SFR_WDATA_OUT, RDATA_OUT;
  logic [11:0] INDEX_BASE_IN, ADDR_OUT;
  int mismatches = 0, checks = 0, cyc = 0;
  dmbm_mapper DUT (
    .CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN), .BANK_WR_IN(BANK_WR_IN),
    .BANK_DATA_IN(BANK_DATA_IN),
    .EXTENDED_INSTRUCTION_ENABLE_IN(EXTENDED_INSTRUCTION_ENABLE_IN),
    .INDEX_BASE_IN(INDEX_BASE_IN), .REQ_IN(REQ_IN),
    .ACCESS_SEL_IN(ACCESS_SEL_IN), .OFFSET_IN(OFFSET_IN), .WR_IN(WR_IN),
    .WDATA_IN(WDATA_IN), .SFR_RDATA_IN(SFR_RDATA_IN), .BANK_OUT(BANK_OUT),
    .ADDR_OUT(ADDR_OUT), .ADDR_VALID_OUT(ADDR_VALID_OUT),
    .RAM_HIT_OUT(RAM_HIT_OUT), .SFR_HIT_OUT(SFR_HIT_OUT),
    .SFR_WR_OUT(SFR_WR_OUT), .SFR_WDATA_OUT(SFR_WDATA_OUT),
    .RDATA_OUT(RDATA_OUT)
  );
  initial
  begin
    CLK_SYS_IN = 0;
    forever #5 CLK_SYS_IN = ~CLK_SYS_IN;
  end
  always @(posedge CLK_SYS_IN)
  begin
    cyc <= cyc + 1;
    if (cyc == 400)
    begin
      mismatches++;
      test_done;
    end
  end
  task chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task rst;
    RESET_IN = 1;
    repeat (6) @(posedge CLK_SYS_IN);
    #1 RESET_IN = 0;
  endtask
  task acc(input logic s, input logic [7:0] o, w, d);
    @(posedge CLK_SYS_IN) #1;
    {REQ_IN, ACCESS_SEL_IN, OFFSET_IN, WR_IN, WDATA_IN} = {1'h1, s, o, w[0], d};
    @(posedge CLK_SYS_IN) #1;
    REQ_IN = 0;
    WR_IN = 0;
  endtask
  task bank(input logic [3:0] b);
    @(posedge CLK_SYS_IN) #1;
    {BANK_WR_IN, BANK_DATA_IN} = {1'h1, b};
    @(posedge CLK_SYS_IN) #1;
    BANK_WR_IN = 0;
    chk(BANK_OUT, b);
  endtask
  task t_window;
    bank(4'h5);
    acc(0, 8'h00, 0, 0);
    chk(ADDR_OUT, 12'h000);
    acc(0, 8'h5F, 0, 0);
    chk(ADDR_OUT, 12'h05F);
    acc(0, 8'h60, 0, 0);
    chk(ADDR_OUT, 12'hF60);
    chk(ADDR_VALID_OUT, 12'h001);
    chk(RDATA_OUT, 12'h05A);
    acc(0, 8'hFF, 0, 0);
    chk(ADDR_OUT, 12'hFFF);
  endtask
  task t_sfr;
    acc(0, 8'h80, 1, 8'h3C);
    chk(ADDR_OUT, 12'hF80);
    chk(SFR_HIT_OUT, 12'h001);
    chk(SFR_WR_OUT, 12'h001);
    chk(SFR_WDATA_OUT, 12'h03C);
    chk(RAM_HIT_OUT, 12'h000);
    @(posedge CLK_SYS_IN) #1;
    chk(SFR_WR_OUT, 12'h000);
    chk(ADDR_VALID_OUT, 12'h000);
    bank(4'h8);
    acc(1, 8'h00, 0, 0);
    chk(ADDR_OUT, 12'h800);
    chk(RAM_HIT_OUT, 12'h000);
    chk(SFR_HIT_OUT, 12'h000);
    chk(RDATA_OUT, 12'h000);
  endtask
  task t_banked;
    bank(4'h3);
    acc(1, 8'h12, 0, 0);
    chk(ADDR_OUT, 12'h312);
  endtask
  task t_ram;
    acc(0, 8'h10, 1, 8'hAA);
    bank(4'h0);
    acc(1, 8'h10, 0, 0);
    chk(RDATA_OUT, 12'h0AA);
    chk(RAM_HIT_OUT, 12'h001);
    rst;
    acc(0, 8'h10, 0, 0);
    chk(RDATA_OUT, 12'h0AA);
  endtask
  task t_ext;
    {EXTENDED_INSTRUCTION_ENABLE_IN, INDEX_BASE_IN} = {1'h1, 12'h100};
    acc(0, 8'h05, 0, 0);
    chk(ADDR_OUT, 12'h105);
    acc(0, 8'h70, 0, 0);
    chk(ADDR_OUT, 12'hF70);
    EXTENDED_INSTRUCTION_ENABLE_IN = 0;
  endtask
  initial
  begin
    {BANK_WR_IN, REQ_IN, ACCESS_SEL_IN, WR_IN} = '0;
    {EXTENDED_INSTRUCTION_ENABLE_IN, BANK_DATA_IN, OFFSET_IN} = '0;
    {WDATA_IN, INDEX_BASE_IN, SFR_RDATA_IN} = {20'h00000, 8'h5A};
    rst;
    t_window;
    t_sfr;
    t_banked;
    t_ram;
    t_ext;
    test_done;
  end
endmodule // tb
